// ==== src/pcu_regs.vh ====
`ifndef PCU_REGS_VH
`define PCU_REGS_VH
// Register indices on the plain register port
`define PCU_ADDR_W 4
`define PCU_REG_CTRL 4'h0
`define PCU_REG_STATUS 4'h1
`define PCU_REG_WAKE_EN 4'h2
`define PCU_REG_GPIO_WEN 4'h3
`define PCU_REG_GPIO_POL 4'h4
`define PCU_REG_RET 4'h5
`define PCU_REG_PER_USE 4'h6
`define PCU_REG_WAKE_SRC 4'h7
// Control register fields
`define PCU_CTRL_MODE_LSB 0
`define PCU_CTRL_MODE_W 3
`define PCU_CTRL_GO_BIT 3
`define PCU_CTRL_TOD_BIT 4
// Requested mode encodings
`define PCU_REQ_SLEEP 3'h1
`define PCU_REQ_DEEP 3'h2
`define PCU_REQ_PART 3'h3
`define PCU_REQ_SHUT 3'h4
// Wake enable fields
`define PCU_WEN_SER_BIT 0
`define PCU_WEN_TMR0_BIT 1
`define PCU_WEN_TMR1_BIT 2
`define PCU_WEN_SEC_BIT 3
`define PCU_WEN_SUB_BIT 4
`define PCU_WEN_PER_BIT 5
// Widths and reset values
`define PCU_GPIO_W 28
`define PCU_PER_W 16
`define PCU_BANKS 4
`define PCU_RET_RST 4'hf
`define PCU_WEN_RST 6'h00
// Wake-up settling time in ns, clock period in ns, and init counter load in cycles (the init phase lasts one cycle more)
`define PCU_OSC_SETTLE_NS 2000
`define PCU_CLK_NS 40
`define PCU_INIT_CYC 8'h20
`endif

// ==== src/pcu_power_ctrl.v ====
`timescale 1ns/1ps
`include "pcu_regs.vh"
`default_nettype none
module pcu_power_ctrl
(
	input wire CORE_CLK_IN,
	input wire SRST_IN,
	input wire [3:0] REG_ADDR_IN,
	input wire [31:0] REG_WDATA_IN,
	input wire REG_WR_IN,
	input wire REG_RD_IN,
	output reg [31:0] REG_RDATA_OUT,
	input wire CORE_BUS_IDLE_IN,
	input wire [`PCU_GPIO_W-1:0] GPIO_PIN_IN,
	input wire PER_IRQ_IN,
	input wire SER_WAKE_IN,
	input wire TMR0_WAKE_IN,
	input wire TMR1_WAKE_IN,
	input wire SEC_ALARM_IN,
	input wire SUB_ALARM_IN,
	input wire EXT_SQ_CLK_SEL_IN,
	output reg CPU_HALT_OUT,
	output reg CPU_PWR_EN_OUT,
	output reg PER_PWR_EN_OUT,
	output reg [`PCU_PER_W-1:0] PER_CLK_EN_OUT,
	output reg DMA_EN_OUT,
	output reg SYS_OSC_EN_OUT,
	output reg XTAL_EN_OUT,
	output reg AON_EXT_CLK_SEL_OUT,
	output reg [`PCU_BANKS-1:0] SRAM_RET_OUT,
	output reg GPIO_HOLD_OUT,
	output reg SYS_INIT_OUT,
	output reg TOD_RUN_OUT
);

	// One-hot mode states
	localparam [6:0] ST_RUN = 7'h01;
	localparam [6:0] ST_SLEEP = 7'h02;
	localparam [6:0] ST_DEEP = 7'h04;
	localparam [6:0] ST_PART = 7'h08;
	localparam [6:0] ST_SHUT = 7'h10;
	localparam [6:0] ST_OSC = 7'h20;
	localparam [6:0] ST_INIT = 7'h40;

	// Oscillator settle count, rounded up to whole cycles
	localparam integer OSC_CYC_I =
		(`PCU_OSC_SETTLE_NS + `PCU_CLK_NS - 1) / `PCU_CLK_NS;
	localparam [7:0] OSC_CYC = OSC_CYC_I[7:0];

	// Register state
	reg [6:0] state_q, state_d;
	reg [2:0] req_mode_q; // Mode to enter
	reg go_q; // Pending entry request
	reg tod_en_q; // Time-of-day run in shutdown
	reg [5:0] wake_en_q; // Wake source enables
	reg [`PCU_GPIO_W-1:0] gpio_wen_q; // Per-pin wake enable
	reg [`PCU_GPIO_W-1:0] gpio_pol_q; // 1 = rising, 0 = falling
	reg [`PCU_BANKS-1:0] ret_q; // Bank retention select
	reg [`PCU_PER_W-1:0] per_use_q; // Peripherals in use
	reg [6:0] wake_src_q; // Sticky wake cause
	reg [7:0] cnt_q; // Settle and init counter
	reg from_deep_q; // Waking from deep retention
	reg ext_sel_q; // Registered clock select

	// Pin synchronisers
	reg [`PCU_GPIO_W-1:0] gpio_s1_q, gpio_s2_q, gpio_s3_q;
	reg [4:0] ev_s1_q, ev_s2_q;

	// Edge detect per pin, chosen polarity
	wire [`PCU_GPIO_W-1:0] rise = gpio_s2_q & ~gpio_s3_q;
	wire [`PCU_GPIO_W-1:0] fall = ~gpio_s2_q & gpio_s3_q;
	wire gpio_wake = |(gpio_wen_q &
		((gpio_pol_q & rise) | (~gpio_pol_q & fall)));

	// Low-power sources shared by both retention modes; per_wake wakes sleep only
	wire lp_wake = (wake_en_q[`PCU_WEN_SER_BIT] & ev_s2_q[0]) |
		(wake_en_q[`PCU_WEN_TMR0_BIT] & ev_s2_q[1]) |
		(wake_en_q[`PCU_WEN_TMR1_BIT] & ev_s2_q[2]);
	wire alarm_wake = (wake_en_q[`PCU_WEN_SEC_BIT] & ev_s2_q[3]) |
		(wake_en_q[`PCU_WEN_SUB_BIT] & ev_s2_q[4]);
	wire per_wake = wake_en_q[`PCU_WEN_PER_BIT] & PER_IRQ_IN;
	wire ret_wake = gpio_wake | lp_wake | alarm_wake;

	// Synchronise outside inputs
	always @(posedge CORE_CLK_IN)
	begin
		if (SRST_IN)
		begin
			gpio_s1_q <= {`PCU_GPIO_W{1'b0}};
			gpio_s2_q <= {`PCU_GPIO_W{1'b0}};
			gpio_s3_q <= {`PCU_GPIO_W{1'b0}};
			ev_s1_q <= 5'h00;
			ev_s2_q <= 5'h00;
		end
		else
		begin
			gpio_s1_q <= GPIO_PIN_IN;
			gpio_s2_q <= gpio_s1_q;
			gpio_s3_q <= gpio_s2_q;
			ev_s1_q <= {SUB_ALARM_IN, SEC_ALARM_IN, TMR1_WAKE_IN,
				TMR0_WAKE_IN, SER_WAKE_IN};
			ev_s2_q <= ev_s1_q;
		end
	end

	// Mode sequencer next state
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_RUN:
			begin
				// Enter only once the core is quiet
				if (go_q && CORE_BUS_IDLE_IN)
				begin
					case (req_mode_q)
						`PCU_REQ_SLEEP: state_d = ST_SLEEP;
						`PCU_REQ_DEEP: state_d = ST_DEEP;
						`PCU_REQ_PART: state_d = ST_PART;
						`PCU_REQ_SHUT: state_d = ST_SHUT;
						default: state_d = ST_RUN;
					endcase
				end
			end
			ST_SLEEP:
			begin
				// Clocks run, so straight back to run
				if (gpio_wake || per_wake || alarm_wake)
					state_d = ST_RUN;
			end
			ST_DEEP:
			begin
				if (ret_wake)
					state_d = ST_OSC;
			end
			ST_PART:
			begin
				if (ret_wake)
					state_d = ST_OSC;
			end
			ST_SHUT:
			begin
				if (gpio_wake)
					state_d = ST_OSC;
			end
			ST_OSC:
			begin
				// Wait for oscillators, then skip init after deep
				if (cnt_q == 8'h00)
					state_d = from_deep_q ? ST_RUN : ST_INIT;
			end
			ST_INIT:
			begin
				if (cnt_q == 8'h00)
					state_d = ST_RUN;
			end
			default: state_d = ST_RUN;
		endcase
	end

	// Sequencer, counters and register writes
	always @(posedge CORE_CLK_IN)
	begin
		if (SRST_IN)
		begin
			state_q <= ST_RUN;
			req_mode_q <= 3'h0;
			go_q <= 1'b0;
			tod_en_q <= 1'b0;
			wake_en_q <= `PCU_WEN_RST;
			gpio_wen_q <= {`PCU_GPIO_W{1'b0}};
			gpio_pol_q <= {`PCU_GPIO_W{1'b0}};
			ret_q <= `PCU_RET_RST;
			per_use_q <= {`PCU_PER_W{1'b1}};
			wake_src_q <= 7'h00;
			cnt_q <= 8'h00;
			from_deep_q <= 1'b0;
			ext_sel_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			ext_sel_q <= EXT_SQ_CLK_SEL_IN;
			// Request is consumed on entry
			if (state_q == ST_RUN && state_d != ST_RUN)
				go_q <= 1'b0;
			else if (REG_WR_IN && REG_ADDR_IN == `PCU_REG_CTRL)
				go_q <= REG_WDATA_IN[`PCU_CTRL_GO_BIT];
			// Load settle count on leaving a retention or shutdown mode
			if (state_d == ST_OSC && state_q != ST_OSC)
			begin
				cnt_q <= OSC_CYC - 8'h01;
				from_deep_q <= (state_q == ST_DEEP);
			end
			else if (state_d == ST_INIT && state_q != ST_INIT)
				cnt_q <= `PCU_INIT_CYC;
			else if (cnt_q != 8'h00)
				cnt_q <= cnt_q - 8'h01;
			// Register writes
			if (REG_WR_IN)
			begin
				case (REG_ADDR_IN)
					`PCU_REG_CTRL:
					begin
						req_mode_q <= REG_WDATA_IN[2:0];
						tod_en_q <= REG_WDATA_IN[`PCU_CTRL_TOD_BIT];
					end
					`PCU_REG_WAKE_EN: wake_en_q <= REG_WDATA_IN[5:0];
					`PCU_REG_GPIO_WEN:
						gpio_wen_q <= REG_WDATA_IN[`PCU_GPIO_W-1:0];
					`PCU_REG_GPIO_POL:
						gpio_pol_q <= REG_WDATA_IN[`PCU_GPIO_W-1:0];
					`PCU_REG_RET: ret_q <= REG_WDATA_IN[3:0];
					`PCU_REG_PER_USE:
						per_use_q <= REG_WDATA_IN[`PCU_PER_W-1:0];
					default: ;
				endcase
			end
			// Wake cause: set wins over write-one-to-clear
			wake_src_q <= (wake_src_q &
				~((REG_WR_IN && REG_ADDR_IN == `PCU_REG_WAKE_SRC) ?
				REG_WDATA_IN[6:0] : 7'h00)) |
				{per_wake, ev_s2_q & wake_en_q[4:0] & 5'h1f, gpio_wake};
		end
	end

	// Power, clock and retention outputs per mode
	always @(posedge CORE_CLK_IN)
	begin
		if (SRST_IN)
		begin
			CPU_HALT_OUT <= 1'b0;
			CPU_PWR_EN_OUT <= 1'b1;
			PER_PWR_EN_OUT <= 1'b1;
			PER_CLK_EN_OUT <= {`PCU_PER_W{1'b1}};
			DMA_EN_OUT <= 1'b1;
			SYS_OSC_EN_OUT <= 1'b1;
			XTAL_EN_OUT <= 1'b1;
			AON_EXT_CLK_SEL_OUT <= 1'b0;
			SRAM_RET_OUT <= {`PCU_BANKS{1'b1}};
			GPIO_HOLD_OUT <= 1'b0;
			SYS_INIT_OUT <= 1'b0;
			TOD_RUN_OUT <= 1'b1;
		end
		else
		begin
			AON_EXT_CLK_SEL_OUT <= ext_sel_q;
			// Halt the CPU outside run
			CPU_HALT_OUT <= (state_d != ST_RUN);
			// CPU power off in retention and shutdown
			CPU_PWR_EN_OUT <= !(state_d == ST_DEEP || state_d == ST_PART ||
				state_d == ST_SHUT);
			PER_PWR_EN_OUT <= (state_d != ST_SHUT);
			// Gating in run, all clocks in sleep, none below
			if (state_d == ST_RUN)
				PER_CLK_EN_OUT <= per_use_q;
			else if (state_d == ST_SLEEP)
				PER_CLK_EN_OUT <= {`PCU_PER_W{1'b1}};
			else
				PER_CLK_EN_OUT <= {`PCU_PER_W{1'b0}};
			DMA_EN_OUT <= (state_d == ST_RUN || state_d == ST_SLEEP);
			// Oscillators follow the mode
			SYS_OSC_EN_OUT <= (state_d == ST_RUN || state_d == ST_SLEEP ||
				state_d == ST_OSC || state_d == ST_INIT);
			XTAL_EN_OUT <= (state_d == ST_RUN || state_d == ST_SLEEP ||
				state_d == ST_OSC || state_d == ST_INIT);
			// SRAM retention per mode
			if (state_d == ST_DEEP)
				SRAM_RET_OUT <= {`PCU_BANKS{1'b1}};
			else if (state_d == ST_PART)
				SRAM_RET_OUT <= ret_q;
			else if (state_d == ST_SHUT)
				SRAM_RET_OUT <= {`PCU_BANKS{1'b0}};
			else
				SRAM_RET_OUT <= {`PCU_BANKS{1'b1}};
			// Freeze pins through deep retention
			// Old deep flag is stale on the edge that leaves partial
			GPIO_HOLD_OUT <= (state_d == ST_DEEP) ||
				(state_d == ST_OSC && (state_q == ST_DEEP ||
				(state_q == ST_OSC && from_deep_q)));
			SYS_INIT_OUT <= (state_d == ST_INIT);
			TOD_RUN_OUT <= (state_d != ST_SHUT) || tod_en_q;
		end
	end

	// Register read port, data one cycle later
	always @(posedge CORE_CLK_IN)
	begin
		if (SRST_IN)
			REG_RDATA_OUT <= 32'h00000000;
		else if (REG_RD_IN)
		begin
			case (REG_ADDR_IN)
				`PCU_REG_CTRL: REG_RDATA_OUT <= {27'h0, tod_en_q, go_q,
					req_mode_q};
				`PCU_REG_STATUS: REG_RDATA_OUT <= {24'h0, from_deep_q,
					state_q};
				`PCU_REG_WAKE_EN: REG_RDATA_OUT <= {26'h0, wake_en_q};
				`PCU_REG_GPIO_WEN: REG_RDATA_OUT <= {4'h0, gpio_wen_q};
				`PCU_REG_GPIO_POL: REG_RDATA_OUT <= {4'h0, gpio_pol_q};
				`PCU_REG_RET: REG_RDATA_OUT <= {28'h0, ret_q};
				`PCU_REG_PER_USE: REG_RDATA_OUT <= {16'h0, per_use_q};
				`PCU_REG_WAKE_SRC: REG_RDATA_OUT <= {25'h0, wake_src_q};
				default: REG_RDATA_OUT <= 32'h00000000;
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== bench/pcu_power_ctrl_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of mode entry, retention and wake order
module pcu_power_ctrl_chk
(
	input wire logic CORE_CLK_IN,
	input wire logic SRST_IN,
	input wire logic CORE_BUS_IDLE_IN,
	input wire logic CPU_HALT_OUT,
	input wire logic CPU_PWR_EN_OUT,
	input wire logic PER_PWR_EN_OUT,
	input wire logic DMA_EN_OUT,
	input wire logic SYS_OSC_EN_OUT,
	input wire logic XTAL_EN_OUT,
	input wire logic [3:0] SRAM_RET_OUT,
	input wire logic GPIO_HOLD_OUT,
	input wire logic SYS_INIT_OUT
);
	// One clock domain, reset masks every check
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (SRST_IN);
	entry_bus_idle_a: assert property (
		$rose(CPU_HALT_OUT) |-> $past(CORE_BUS_IDLE_IN))
		else $error("mode entered while core bus busy");
	sleep_keeps_per_a: assert property (
		$rose(CPU_HALT_OUT) && CPU_PWR_EN_OUT |-> PER_PWR_EN_OUT && DMA_EN_OUT)
		else $error("sleep dropped peripherals or dma");
	hold_osc_off_a: assert property (
		$rose(GPIO_HOLD_OUT) |-> !SYS_OSC_EN_OUT && !XTAL_EN_OUT)
		else $error("pin hold with oscillators running");
	shut_no_ret_a: assert property (
		$fell(PER_PWR_EN_OUT) |-> SRAM_RET_OUT == 4'h0 && !CPU_PWR_EN_OUT)
		else $error("shutdown kept sram or cpu power");
	init_length_a: assert property (
		$rose(SYS_INIT_OUT) |-> ##32 SYS_INIT_OUT ##[1:2] !SYS_INIT_OUT)
		else $error("init phase length wrong");
	deep_skip_init_a: assert property (
		$fell(GPIO_HOLD_OUT) |-> !SYS_INIT_OUT && !$past(SYS_INIT_OUT))
		else $error("deep retention wake ran init");
	run_osc_on_a: assert property (
		!CPU_HALT_OUT |-> SYS_OSC_EN_OUT && XTAL_EN_OUT && CPU_PWR_EN_OUT)
		else $error("cpu running without oscillators");
	wake_osc_first_a: assert property (
		$fell(CPU_HALT_OUT) |-> $past(SYS_OSC_EN_OUT, 2) && $past(XTAL_EN_OUT, 2))
		else $error("cpu released before oscillators");
endmodule
bind pcu_power_ctrl pcu_power_ctrl_chk pcu_power_ctrl_chk_i (
	.CORE_CLK_IN(CORE_CLK_IN), .SRST_IN(SRST_IN),
	.CORE_BUS_IDLE_IN(CORE_BUS_IDLE_IN), .CPU_HALT_OUT(CPU_HALT_OUT),
	.CPU_PWR_EN_OUT(CPU_PWR_EN_OUT), .PER_PWR_EN_OUT(PER_PWR_EN_OUT),
	.DMA_EN_OUT(DMA_EN_OUT), .SYS_OSC_EN_OUT(SYS_OSC_EN_OUT),
	.XTAL_EN_OUT(XTAL_EN_OUT), .SRAM_RET_OUT(SRAM_RET_OUT),
	.GPIO_HOLD_OUT(GPIO_HOLD_OUT), .SYS_INIT_OUT(SYS_INIT_OUT));
`default_nettype wire

// ==== bench/pcu_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Core stand-in: drains its bus before it lets a mode start
module pcu_core_model
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sleep_in,
	output logic bus_idle_out
);
	// Cycles of bus traffic drained so far
	logic [1:0] drain_q;
	// Idle only once the drain count has reached 3
	always_ff @(posedge clk_in)
	begin
		if (rst_in || !sleep_in)
		begin
			drain_q <= 2'h0;
			bus_idle_out <= 1'b0;
		end
		else if (drain_q != 2'h3)
			drain_q <= drain_q + 2'h1;
		else
			bus_idle_out <= 1'b1;
	end
endmodule
`default_nettype wire

// ==== bench/pcu_power_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcu_power_ctrl_tb_top;
	logic clk, srst, reg_wr, reg_rd, per_irq, ser, sub, ext_sel, sleep;
	logic tmr0, tmr1, sec;
	logic [3:0] addr, ret;
	logic [31:0] wdata, rdata;
	logic [27:0] gpio;
	logic idle, halt, cpu_pwr, per_pwr, dma, osc, xtal, aon_sel, hold, init, tod;
	logic [15:0] per_clk;
	logic saw_init;
	int n_errors, n_tests;
	pcu_power_ctrl pcu_power_ctrl_i (.CORE_CLK_IN(clk), .SRST_IN(srst),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(reg_wr),
		.REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata), .CORE_BUS_IDLE_IN(idle),
		.GPIO_PIN_IN(gpio), .PER_IRQ_IN(per_irq), .SER_WAKE_IN(ser),
		.TMR0_WAKE_IN(tmr0), .TMR1_WAKE_IN(tmr1), .SEC_ALARM_IN(sec),
		.SUB_ALARM_IN(sub), .EXT_SQ_CLK_SEL_IN(ext_sel), .CPU_HALT_OUT(halt),
		.CPU_PWR_EN_OUT(cpu_pwr), .PER_PWR_EN_OUT(per_pwr),
		.PER_CLK_EN_OUT(per_clk), .DMA_EN_OUT(dma), .SYS_OSC_EN_OUT(osc),
		.XTAL_EN_OUT(xtal), .AON_EXT_CLK_SEL_OUT(aon_sel),
		.SRAM_RET_OUT(ret), .GPIO_HOLD_OUT(hold), .SYS_INIT_OUT(init),
		.TOD_RUN_OUT(tod));
	pcu_core_model pcu_core_model_i (.clk_in(clk), .rst_in(srst),
		.sleep_in(sleep), .bus_idle_out(idle));
	// 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task bus_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data appears in the cycle after the strobe and holds until the next read
	task bus_rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask
	// Bounded wait on the halt level, noting any init phase
	task wait_halt(input logic want);
		int i;
		i = 0;
		while (halt !== want && i < 300)
		begin
			@(negedge clk);
			saw_init |= init;
			i++;
		end
		if (halt !== want)
		begin
			n_errors++;
			conclude;
		end
	endtask
	task enter(input logic [31:0] ctrl);
		bus_wr(4'h0, ctrl);
		@(posedge clk);
		sleep <= 1'b1;
		wait_halt(1'b1);
		saw_init = 1'b0;
	endtask
	task settle;
		@(posedge clk);
		sleep <= 1'b0;
		per_irq <= 1'b0;
		sub <= 1'b0;
		ser <= 1'b0;
		tmr0 <= 1'b0;
		tmr1 <= 1'b0;
		sec <= 1'b0;
	endtask
	task t_reset;
		@(negedge clk);
		chk({halt, cpu_pwr, per_pwr, dma, osc, xtal, hold, init, tod}, 9'hf9);
		chk(per_clk, 32'hffff);
		chk(ret, 32'hf);
		@(posedge clk);
		ext_sel <= 1'b1;
		repeat (4) @(negedge clk);
		chk(aon_sel, 32'h1);
		bus_rd(4'hf, 32'h0);
		bus_wr(4'h6, 32'hf0f0);
		repeat (3) @(negedge clk);
		chk(per_clk, 32'hf0f0);
		bus_rd(4'h5, 32'hf);
		$display("test reset done");
	endtask
	task t_sleep;
		bus_wr(4'h2, 32'h20);
		enter(32'h09);
		chk({cpu_pwr, per_pwr, dma}, 32'h7);
		@(posedge clk);
		per_irq <= 1'b1;
		wait_halt(1'b0);
		chk(saw_init, 32'h0);
		settle;
		$display("test sleep done");
	endtask
	task t_deep;
		bus_wr(4'h3, 32'h8);
		bus_wr(4'h4, 32'h8);
		enter(32'h0a);
		chk({cpu_pwr, osc, xtal, hold, dma}, 32'h2);
		chk({ret, per_clk}, 32'hf0000);
		@(posedge clk);
		gpio[3] <= 1'b1;
		wait_halt(1'b0);
		chk({saw_init, hold}, 32'h0);
		settle;
		$display("test deep done");
	endtask
	task t_part;
		bus_wr(4'h5, 32'h5);
		bus_wr(4'h2, 32'h10);
		enter(32'h0b);
		chk({cpu_pwr, ret}, 32'h5);
		@(posedge clk);
		sub <= 1'b1;
		wait_halt(1'b0);
		chk(saw_init, 32'h1);
		settle;
		$display("test partial done");
	endtask
	task t_shut;
		bus_wr(4'h2, 32'h1);
		bus_wr(4'h3, 32'h1);
		bus_wr(4'h4, 32'h0);
		@(posedge clk);
		gpio[0] <= 1'b1;
		enter(32'h1c);
		chk({cpu_pwr, per_pwr, ret, tod}, 32'h1);
		@(posedge clk);
		ser <= 1'b1;
		repeat (20) @(negedge clk);
		chk(halt, 32'h1);
		@(posedge clk);
		gpio[0] <= 1'b0;
		wait_halt(1'b0);
		chk(saw_init, 32'h1);
		settle;
		// Second shutdown without the time-of-day enable
		@(posedge clk);
		gpio[0] <= 1'b1;
		enter(32'h0c);
		chk(tod, 32'h0);
		@(posedge clk);
		gpio[0] <= 1'b0;
		wait_halt(1'b0);
		chk(saw_init, 32'h1);
		settle;
		$display("test shutdown done");
	endtask
	// Timer wakes in both retention modes, seconds alarm in sleep
	task t_lp;
		bus_wr(4'h7, 32'h7f);
		bus_wr(4'h2, 32'h06);
		enter(32'h0a);
		@(posedge clk);
		tmr0 <= 1'b1;
		wait_halt(1'b0);
		chk({saw_init, hold}, 32'h0);
		settle;
		enter(32'h0b);
		chk(hold, 32'h0);
		@(posedge clk);
		tmr1 <= 1'b1;
		wait_halt(1'b0);
		chk({saw_init, hold}, 32'h2);
		settle;
		bus_wr(4'h2, 32'h08);
		enter(32'h09);
		@(posedge clk);
		sec <= 1'b1;
		wait_halt(1'b0);
		chk(saw_init, 32'h0);
		bus_rd(4'h7, 32'h1c);
		bus_wr(4'h7, 32'h1c);
		bus_rd(4'h7, 32'h10);
		settle;
		$display("test low-power sources done");
	endtask
	// Main sequence
	initial
	begin
		srst = 1'b1;
		{reg_wr, reg_rd, per_irq, ser, sub, ext_sel, sleep} = 7'h0;
		{tmr0, tmr1, sec} = 3'h0;
		addr = 4'h0;
		wdata = 32'h0;
		gpio = 28'h0;
		saw_init = 1'b0;
		n_errors = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_sleep;
		t_deep;
		t_part;
		t_shut;
		t_lp;
		conclude;
	end
endmodule
`default_nettype wire
